// ==== hw/pss_pkg.sv ====
// Package of constants, states and carriers for the primary switch supervisor
package pss_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned CLK_NS = 40;
  // Times in their own units
  localparam int unsigned SKIP_US = 25;
  localparam int unsigned RSG_OFF_US = 30;
  localparam int unsigned SENSE_OFF_US = 50;
  localparam int unsigned HS_GAP_US = 30;
  localparam int unsigned OVL_PERSIST_MS = 82;
  localparam int unsigned OVL_FREQ_KHZ = 110;
  localparam int unsigned EARLY_NS = 500;
  localparam int unsigned RSG_NS = 200;
  localparam int unsigned RESTART_OFF_MS = 1500;
  localparam int unsigned SHORT_OFF_MS = 2000;
  localparam int unsigned LOSS_MS = 1500;
  localparam int unsigned BROWNOUT_MS = 35;
  // Cycle counts derived from the clock rate
  localparam int unsigned SKIP_CYC = SKIP_US * (CLK_HZ / 1000000);
  localparam int unsigned RSG_OFF_CYC = RSG_OFF_US * (CLK_HZ / 1000000);
  localparam int unsigned SENSE_OFF_CYC = SENSE_OFF_US * (CLK_HZ / 1000000);
  localparam int unsigned HS_GAP_CYC = HS_GAP_US * (CLK_HZ / 1000000);
  localparam int unsigned OVL_PERIOD_CYC = CLK_HZ / (OVL_FREQ_KHZ * 1000);
  localparam int unsigned EARLY_CYC = EARLY_NS / CLK_NS;
  localparam int unsigned RSG_CYC = RSG_NS / CLK_NS;
  localparam int unsigned OVL_PERSIST_CYC = OVL_PERSIST_MS * (CLK_HZ / 1000);
  localparam int unsigned RESTART_OFF_CYC = RESTART_OFF_MS * (CLK_HZ / 1000);
  localparam int unsigned SHORT_OFF_CYC = SHORT_OFF_MS * (CLK_HZ / 1000);
  localparam int unsigned LOSS_CYC = LOSS_MS * (CLK_HZ / 1000);
  localparam int unsigned BROWNOUT_CYC = BROWNOUT_MS * (CLK_HZ / 1000);
  // Threshold scale: 1000 is full limit
  localparam logic [9:0] LIM_FULL = 10'h3e8;
  localparam logic [9:0] LIM_FLOOR = 10'h12c;
  localparam logic [9:0] JIT_DEPTH = 10'h032;
  localparam logic [9:0] LIM_SLOPE = 10'h001;
  localparam int unsigned JIT_HALF_CYC = 100000;
  localparam int unsigned NSYNC = 11;
  // Flag order counting from uv45; synchroniser bit is NSYNC-1 minus this
  localparam int unsigned S_UV45 = 0;
  localparam int unsigned S_CLAMP = 1;
  localparam int unsigned S_RST3 = 2;
  localparam int unsigned S_OVER_CUR = 3;
  localparam int unsigned S_HOT = 4;
  localparam int unsigned S_COOL = 5;
  localparam int unsigned S_BIN = 6;
  localparam int unsigned S_BOUT = 7;
  localparam int unsigned S_LOV = 8;
  localparam int unsigned S_REQ = 9;
  localparam int unsigned S_LIM = 10;

  typedef enum logic [2:0] {
    ST_CHARGE  = 3'h0,
    ST_LINECHK = 3'h1,
    ST_LISTEN  = 3'h2,
    ST_RUN     = 3'h3,
    ST_RESTART = 3'h4,
    ST_LATCHED = 3'h5
  } pss_state_type;

  typedef struct packed {
    logic uv45;      // supply below 4.5 V
    logic clamp;     // supply at shunt clamp
    logic rst3;      // supply below 3 V
    logic over_cur;  // supply current over shutdown level
    logic hot;       // die over limit
    logic cool;      // die cooled by hysteresis
    logic brownin;   // line above brown-in
    logic brownout;  // line below brown-out
    logic line_ov;   // line over overvoltage
    logic req;       // secondary request pulse
    logic lim_hit;   // drain current at threshold
  } pss_flags_type;

  typedef struct packed {
    logic big_cap;   // increased limit chosen
    logic latch_opt; // latching faults chosen
  } pss_cfg_type;

  typedef struct packed {
    logic [NSYNC-1:0] s1;
    logic [NSYNC-1:0] s2;
    logic             req_d;
    logic             lim_d;
    pss_state_type    st;
    pss_cfg_type      cfg;
    logic             uv_lock;
    logic             hot_lock;
    logic             secondary;
    logic             gate;
    logic [5:0]       on_cnt;
    logic             early_prev;
    logic             srs_armed;
    logic [31:0]      wait_cnt;
    logic [31:0]      off_cnt;
    logic [31:0]      loss_cnt;
    logic [31:0]      ovl_cnt;
    logic [31:0]      gap_cnt;
    logic [31:0]      bo_cnt;
    logic [31:0]      jit_cnt;
    logic [31:0]      hs_cnt;
    logic             hs_one;
    logic             jit_dn;
    logic [9:0]       jit;
    logic [9:0]       lim;
    logic             sense_on;
  } pss_st_type;
endpackage : pss_pkg

// ==== hw/pss_supervisor.sv ====
// Primary switch protection supervisor: enables, restarts and threshold
module pss_supervisor
  import pss_pkg::*;
#(
  parameter bit          RSG_EN       = 1'b1,           // Rectifier short guard fitted
  parameter int unsigned P_RESTART    = RESTART_OFF_CYC, // Restart off-time cycles
  parameter int unsigned P_SHORT_OFF  = SHORT_OFF_CYC,  // Short restart off-time cycles
  parameter int unsigned P_LOSS       = LOSS_CYC,       // Request loss cycles
  parameter int unsigned P_OVL        = OVL_PERSIST_CYC, // Overload persist cycles
  parameter int unsigned P_BROWNOUT   = BROWNOUT_CYC,   // Brown-out delay cycles
  parameter int unsigned P_LISTEN     = OVL_PERSIST_CYC, // Listen period cycles
  parameter int unsigned P_JIT_HALF   = JIT_HALF_CYC    // Jitter half period cycles
) (
  input  wire logic          i_clock,        // 25 MHz clock
  input  wire logic          i_resetn,       // Sync reset, active low
  input  wire pss_flags_type i_flags,        // Async comparator flags
  input  wire logic          i_big_cap,      // Capacitor size strap
  input  wire logic          i_latch_opt,    // Fault option strap
  input  wire logic          i_gate_req,     // Gate driver asks turn-on
  output logic               o_switch_on,    // Power switch gate
  output logic [9:0]         o_peak_current_threshold, // Threshold, 1000 full
  output logic               o_sense_on,     // Line sense path connected
  output logic               o_secondary,    // Secondary in control
  output logic               o_restart,      // In auto-restart
  output logic               o_latched       // Latched off
);
  pss_st_type    r_r;
  pss_st_type    r_nxt;
  pss_flags_type f;
  logic          req_p;
  logic          lim_p;
  logic          line_rst;
  logic          hold_off;
  logic          fault;
  logic          long_off;

  // Second stage only; first stage feeds nothing else
  assign f = pss_flags_type'(r_r.s2);

  always_comb begin
    r_nxt = r_r;
    r_nxt.s1 = NSYNC'(i_flags);
    r_nxt.s2 = r_r.s1;
    r_nxt.req_d = f.req;
    r_nxt.lim_d = f.lim_hit;
    req_p = f.req & ~r_r.req_d;
    lim_p = f.lim_hit & ~r_r.lim_d;
    line_rst = ~f.brownin & f.brownout;
    long_off = 1'b0;

    // Supply undervoltage lockout with clamp release
    if (f.uv45) begin
      r_nxt.uv_lock = 1'b1;
    end else if (f.clamp) begin
      r_nxt.uv_lock = 1'b0;
    end

    // Thermal response by option
    if (f.hot) begin
      r_nxt.hot_lock = 1'b1;
    end else if (!r_r.cfg.latch_opt && f.cool) begin
      r_nxt.hot_lock = 1'b0;
    end else if (r_r.cfg.latch_opt && (f.rst3 || line_rst)) begin
      r_nxt.hot_lock = 1'b0;
    end

    // Off-time and request timers
    r_nxt.off_cnt = r_r.gate ? 32'h0 : r_r.off_cnt + 32'h1;
    r_nxt.gap_cnt = req_p ? 32'h0 : r_r.gap_cnt + 32'h1;
    r_nxt.loss_cnt = req_p ? 32'h0 : r_r.loss_cnt + 32'h1;
    // Requests faster than overload frequency accumulate
    if (req_p && r_r.gap_cnt < OVL_PERIOD_CYC) begin
      r_nxt.ovl_cnt = r_r.ovl_cnt + 32'h1 + r_r.gap_cnt;
    end else if (req_p || r_r.gap_cnt >= OVL_PERIOD_CYC) begin
      r_nxt.ovl_cnt = 32'h0;
    end
    // Brown-out persistence
    if (f.brownout || (r_r.bo_cnt != 32'h0 && !f.brownin)) begin
      r_nxt.bo_cnt = r_r.bo_cnt + 32'h1;
    end else begin
      r_nxt.bo_cnt = 32'h0;
    end

    // Sense path drops after long off-time, back at next turn-on
    if (r_r.off_cnt >= SENSE_OFF_CYC) begin
      r_nxt.sense_on = 1'b0;
    end
    if (r_nxt.gate) begin
      r_nxt.sense_on = 1'b1;
    end

    // Jitter square wave between full and 95%
    r_nxt.jit_cnt = r_r.jit_cnt + 32'h1;
    if (r_r.jit_cnt >= P_JIT_HALF - 1) begin
      r_nxt.jit_cnt = 32'h0;
      r_nxt.jit_dn = ~r_r.jit_dn;
    end
    r_nxt.jit = r_r.jit_dn ? LIM_FULL - JIT_DEPTH : LIM_FULL;
    // Linear fall with off-time, floor at 30%
    if (r_r.off_cnt >= 32'(r_r.jit - LIM_FLOOR)) begin
      r_nxt.lim = LIM_FLOOR;
    end else begin
      r_nxt.lim = r_r.jit - 10'(r_r.off_cnt) * LIM_SLOPE;
    end

    fault = 1'b0;
    if (r_r.wait_cnt != 32'h0) begin
      r_nxt.wait_cnt = r_r.wait_cnt - 32'h1;
    end

    // Main sequence
    unique case (r_r.st)
      ST_CHARGE: begin
        if (f.clamp) begin
          r_nxt.cfg.big_cap = i_big_cap;
          r_nxt.st = ST_LINECHK;
        end
      end
      ST_LINECHK: begin
        if (f.brownin && !f.line_ov) begin
          r_nxt.st = ST_LISTEN;
          r_nxt.wait_cnt = 32'(P_LISTEN);
          r_nxt.hs_one = 1'b0;
        end
      end
      ST_LISTEN: begin
        // Two requests at most 60 us apart hand control over
        if (req_p) begin
          r_nxt.hs_one = 1'b1;
          r_nxt.hs_cnt = 32'h0;
          if (r_r.hs_one && r_r.hs_cnt <= 2 * HS_GAP_CYC) begin
            r_nxt.secondary = 1'b1;
            r_nxt.st = ST_RUN;
          end
        end else begin
          r_nxt.hs_cnt = r_r.hs_cnt + 32'h1;
        end
        if (r_r.wait_cnt == 32'h0) begin
          r_nxt.secondary = 1'b0;
          r_nxt.st = ST_RUN;
        end
        r_nxt.loss_cnt = 32'h0;
      end
      ST_RUN: begin
        if (f.over_cur) begin
          fault = 1'b1;
        end
        if (r_r.ovl_cnt >= P_OVL) begin
          fault = 1'b1;
        end
        if (r_r.secondary && r_r.loss_cnt >= P_LOSS) begin
          fault = 1'b1;
        end
        if (r_r.bo_cnt >= P_BROWNOUT || f.line_ov) begin
          fault = 1'b1;
        end
        if (fault) begin
          r_nxt.st = (f.over_cur && r_r.cfg.latch_opt) ? ST_LATCHED : ST_RESTART;
          r_nxt.wait_cnt = 32'(P_RESTART);
        end
      end
      ST_RESTART: begin
        if (line_rst) begin
          r_nxt.wait_cnt = 32'h0;
        end
        // Resume only with line in range
        if ((r_r.wait_cnt == 32'h0 || line_rst) && f.brownin && !f.line_ov) begin
          r_nxt.st = ST_LISTEN;
          r_nxt.wait_cnt = 32'(P_LISTEN);
          r_nxt.hs_one = 1'b0;
          r_nxt.bo_cnt = 32'h0;
        end
      end
      ST_LATCHED: begin
        if (f.rst3 || line_rst) begin
          r_nxt.st = ST_CHARGE;
        end
      end
      default: r_nxt.st = ST_CHARGE;
    endcase

    // Turn-on window timing for early current limit
    r_nxt.on_cnt = r_r.gate ? (r_r.on_cnt == 6'h3f ? r_r.on_cnt : r_r.on_cnt + 6'h1) : 6'h0;
    if (r_r.gate && lim_p) begin
      if (RSG_EN && r_r.on_cnt < RSG_CYC) begin
        // Repeat right after the 30 us pause is a shorted rectifier
        if (r_r.srs_armed) begin
          r_nxt.st = ST_RESTART;
          r_nxt.wait_cnt = 32'(P_SHORT_OFF);
          r_nxt.srs_armed = 1'b0;
        end else begin
          r_nxt.wait_cnt = 32'(RSG_OFF_CYC);
          r_nxt.srs_armed = 1'b1;
        end
        r_nxt.early_prev = 1'b0;
      end else if (r_r.on_cnt < EARLY_CYC) begin
        if (r_r.early_prev) begin
          r_nxt.wait_cnt = 32'(SKIP_CYC);
          r_nxt.early_prev = 1'b0;
        end else begin
          r_nxt.early_prev = 1'b1;
        end
        r_nxt.srs_armed = 1'b0;
      end else begin
        r_nxt.early_prev = 1'b0;
        r_nxt.srs_armed = 1'b0;
      end
    end

    // Any state restarts from supply collapse
    if (f.rst3 && r_r.st != ST_CHARGE) begin
      r_nxt.st = ST_CHARGE;
      r_nxt.hot_lock = 1'b0;
    end

    hold_off = r_r.uv_lock | r_r.hot_lock | (r_r.wait_cnt != 32'h0) | long_off;
    // Gate held until limit or request drops
    r_nxt.gate = (r_nxt.st == ST_RUN) && !hold_off && i_gate_req && !(r_r.gate && f.lim_hit);
    r_nxt.secondary = (r_nxt.st == ST_RUN) ? r_nxt.secondary : 1'b0;
  end

  // Straps are taken in every clocked cycle of reset; big_cap again when clamp ends ST_CHARGE
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      r_r <= '0;
      r_r.st <= ST_CHARGE;
      r_r.jit <= LIM_FULL;
      r_r.lim <= LIM_FULL;
      r_r.sense_on <= 1'b1;
      r_r.uv_lock <= 1'b1;
      r_r.cfg.latch_opt <= i_latch_opt;
      r_r.cfg.big_cap <= i_big_cap;
    end else begin
      r_r <= r_nxt;
    end
  end

  // Outputs are register bits or decodes of the registered state
  assign o_switch_on = r_r.gate;
  assign o_peak_current_threshold = r_r.lim;
  assign o_sense_on = r_r.sense_on;
  assign o_secondary = r_r.secondary;
  assign o_restart = (r_r.st == ST_RESTART);
  assign o_latched = (r_r.st == ST_LATCHED);
endmodule : pss_supervisor

// ==== verif/pss_secondary_model.sv ====
// Secondary-side model: bursts of cycle requests
module pss_secondary_model (
  input  wire logic        i_clock, // Clock
  input  wire logic        i_start, // Begin a burst
  input  wire logic [7:0]  i_count, // Pulses in burst
  input  wire logic [15:0] i_gap,   // Cycles between pulses
  output logic             o_req    // Request line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  left_r = 8'h0;
  logic [15:0] cnt_r  = 16'h0;
  // Pulses last three cycles so the two-flop sync sees them
  always_ff @(posedge i_clock) begin
    if (i_start) begin
      left_r <= i_count;
      cnt_r  <= 16'h0;
    end else if (left_r != 8'h0) begin
      cnt_r <= cnt_r + 16'h1;
      if (cnt_r == i_gap - 16'h1) begin
        cnt_r  <= 16'h0;
        left_r <= left_r - 8'h1;
      end
    end
  end
  assign o_req = (left_r != 8'h0) && (cnt_r < 16'h3);
endmodule : pss_secondary_model

// ==== verif/pss_supervisor_asserts.sv ====
// Port checker of the supervisor
module pss_supervisor_asserts
  import pss_pkg::*;
(
  input wire logic          i_clock,                  // Clock
  input wire logic          i_resetn,                 // Reset, active low
  input wire pss_flags_type i_flags,                  // Comparator flags
  input wire logic          i_gate_req,               // Turn-on request
  input wire logic          o_switch_on,              // Gate
  input wire logic [9:0]    o_peak_current_threshold, // Threshold
  input wire logic          o_sense_on,               // Line sense
  input wire logic          o_restart,                // Auto-restart
  input wire logic          o_latched                 // Latched off
);
  localparam int SENSE_MIN = SENSE_OFF_CYC - 2;
  logic [31:0] off_run_r;
  // Off-time count; slack of two covers register skew
  always_ff @(posedge i_clock) begin
    if (!i_resetn || o_switch_on) off_run_r <= 32'h0;
    else off_run_r <= off_run_r + 32'h1;
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  AST_RST: assert property (disable iff (1'b0) !i_resetn |=> !o_switch_on && o_sense_on && !o_restart
    && !o_latched && o_peak_current_threshold == LIM_FULL) else $error("reset values wrong");
  AST_THR_RANGE: assert property (o_peak_current_threshold >= LIM_FLOOR
    && o_peak_current_threshold <= LIM_FULL) else $error("threshold out of range");
  AST_UV_OFF: assert property (i_flags.uv45 [*3] |=> ##1 !o_switch_on) else $error("switch on at low supply");
  AST_HOT_OFF: assert property (i_flags.hot [*3] |=> ##1 !o_switch_on) else $error("switch on when hot");
  AST_RESTART_OFF: assert property (o_restart && $past(o_restart) |-> !o_switch_on)
    else $error("switch on in restart");
  AST_LATCH_OFF: assert property (o_latched && $past(o_latched) |-> !o_switch_on)
    else $error("switch on while latched");
  AST_GATE_CAUSE: assert property ($rose(o_switch_on) |-> $past(i_gate_req) && !o_latched)
    else $error("gate rose without request");
  AST_SENSE_ON: assert property ($rose(o_switch_on) |-> ##[0:1] o_sense_on)
    else $error("sense not reconnected");
  AST_SENSE_OFF: assert property ($fell(o_sense_on) |-> off_run_r >= SENSE_MIN)
    else $error("sense dropped early");
  AST_CLEAR: assert property (o_latched ##0 i_flags.rst3 [*3] |=> ##[0:1] !o_latched)
    else $error("latch not cleared");
endmodule : pss_supervisor_asserts

bind pss_supervisor pss_supervisor_asserts u_chk (.i_clock(i_clock), .i_resetn(i_resetn), .i_flags(i_flags),
  .i_gate_req(i_gate_req), .o_switch_on(o_switch_on), .o_peak_current_threshold(o_peak_current_threshold),
  .o_sense_on(o_sense_on), .o_restart(o_restart), .o_latched(o_latched));

// ==== verif/pss_supervisor_bench.sv ====
// Self-checking bench of the supervisor
module pss_supervisor_bench
  import pss_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock = 1'b0, rstn, gate_req, latch_opt, big_cap, sw, sense, sec, rst_o, lat, h_req, h_start;
  // Shortened timers keep the run small
  localparam int unsigned T_OFF    = 300;
  localparam int unsigned T_LIMIT  = 400;
  localparam int unsigned T_BO     = 200;
  localparam int unsigned T_LISTEN = 1000;
  localparam int unsigned T_JIT    = 200;
  logic [9:0]    thr, t1;
  logic [7:0]    h_count;
  logic [15:0]   h_gap;
  pss_flags_type flags, fl;
  int            num_errors = 0, comparisons = 0, cycles = 0;
  // Partner's request joins the comparator flags
  always_comb begin
    fl = flags;
    fl.req = h_req;
  end
  pss_supervisor #(.P_RESTART(T_OFF), .P_SHORT_OFF(T_OFF), .P_LOSS(T_LIMIT), .P_OVL(T_LIMIT), .P_BROWNOUT(T_BO),
    .P_LISTEN(T_LISTEN), .P_JIT_HALF(T_JIT)) DUT (.i_clock(i_clock), .i_resetn(rstn), .i_flags(fl),
    .i_big_cap(big_cap), .i_latch_opt(latch_opt), .i_gate_req(gate_req), .o_switch_on(sw),
    .o_peak_current_threshold(thr), .o_sense_on(sense), .o_secondary(sec), .o_restart(rst_o), .o_latched(lat));
  pss_secondary_model u_sec (.i_clock(i_clock), .i_start(h_start), .i_count(h_count), .i_gap(h_gap), .o_req(h_req));
  initial forever #20 i_clock = ~i_clock;
  // Hang guard, far above the expected run
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      num_errors++;
      stop_test();
    end
  end
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  // Bounded wait on one output: 0 gate, 1 restart, 2 latched
  task automatic wait_on(input int sel, input logic v, input int lim);
    for (int i = 0; i < lim; i++) begin
      if ({lat, rst_o, sw}[sel] === v) break;
      @(negedge i_clock);
    end
  endtask : wait_on
  task automatic burst(input logic [7:0] n, input logic [15:0] gap);
    h_count = n;
    h_gap = gap;
    h_start = 1'b1;
    @(negedge i_clock);
    h_start = 1'b0;
  endtask : burst
  task automatic stop_test;
    $display("Checks %0d, errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  // Test sequence, inputs move on the falling edge
  initial begin
    flags = '0; gate_req = 1'b1; latch_opt = 1'b0; big_cap = 1'b0; h_start = 1'b0; h_count = 8'h0; h_gap = 16'h0;
    rstn = 1'b0;
    @(negedge i_clock);
    chk(thr, LIM_FULL);
    @(negedge i_clock);
    rstn = 1'b1;
    flags.clamp = 1'b1; flags.brownin = 1'b1; flags.line_ov = 1'b1;
    repeat (300) @(negedge i_clock);
    chk(sw, 1'b0);
    flags.line_ov = 1'b0;
    wait_on(0, 1'b1, 1500);
    chk(sw, 1'b1);
    chk(sec, 1'b0);
    $display("Test startup done");
    flags.uv45 = 1'b1; flags.clamp = 1'b0;
    repeat (5) @(negedge i_clock);
    chk(sw, 1'b0);
    flags.uv45 = 1'b0;
    repeat (20) @(negedge i_clock);
    chk(sw, 1'b0);
    flags.clamp = 1'b1;
    wait_on(0, 1'b1, 1500);
    chk(sw, 1'b1);
    flags.hot = 1'b1;
    repeat (5) @(negedge i_clock);
    chk(sw, 1'b0);
    flags.hot = 1'b0;
    repeat (20) @(negedge i_clock);
    chk(sw, 1'b0);
    flags.cool = 1'b1;
    wait_on(0, 1'b1, 1500);
    chk(sw, 1'b1);
    flags.cool = 1'b0;
    $display("Test supply and thermal done");
    gate_req = 1'b0;
    repeat (100) @(negedge i_clock);
    t1 = thr;
    repeat (100) @(negedge i_clock);
    chk(t1 > thr, 1'b1);
    repeat (1200) @(negedge i_clock);
    chk(thr, LIM_FLOOR);
    chk(sense, 1'b0);
    gate_req = 1'b1;
    wait_on(0, 1'b1, 20);
    repeat (2) @(negedge i_clock);
    chk(sense, 1'b1);
    $display("Test threshold done");
    // Latching option is only taken in reset
    latch_opt = 1'b1; rstn = 1'b0;
    repeat (2) @(negedge i_clock);
    rstn = 1'b1;
    wait_on(0, 1'b1, 1500);
    flags.over_cur = 1'b1;
    wait_on(2, 1'b1, 10);
    chk(lat, 1'b1);
    flags.over_cur = 1'b0; flags.rst3 = 1'b1;
    wait_on(2, 1'b0, 10);
    chk(lat, 1'b0);
    flags.rst3 = 1'b0;
    // Let the supervisor reach its listen state before the first request
    repeat (20) @(negedge i_clock);
    burst(8'h2, HS_GAP_CYC[15:0]);
    wait_on(0, 1'b1, 2500);
    chk(sec, 1'b1);
    wait_on(1, 1'b1, 600);
    chk(rst_o, 1'b1);
    chk(sw, 1'b0);
    wait_on(0, 1'b1, 1500);
    flags.line_ov = 1'b1;
    wait_on(1, 1'b1, 10);
    chk(rst_o, 1'b1);
    flags.line_ov = 1'b0;
    wait_on(0, 1'b1, 1500);
    chk(sw, 1'b1);
    burst(8'h8, 16'h64);
    wait_on(1, 1'b1, 1000);
    chk(rst_o, 1'b1);
    $display("Test faults and handshake done");
    stop_test();
  end
endmodule : pss_supervisor_bench
